/* File: logic/pprs_top.sv */
// Purpose: peripheral pin route select, register file and pin override
// Assumes: AXI4-Lite slave, byte address = register index * 4
// Notes:   three cycles from pad to peripheral input, one to pad output
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module pprs_top
  import pprs_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  input  wire logic [PPRS_AW-1:0]   awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [PPRS_AW-1:0]   araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic [PPRS_NPIN-1:0] gpio_out,
  input  wire logic [PPRS_NPIN-1:0] gpio_drive,
  input  wire logic [PPRS_NPIN-1:0] pad_in,
  output logic [PPRS_NPIN-1:0]      pad_out,
  output logic [PPRS_NPIN-1:0]      pad_oe_n,
  output logic [PPRS_NPIN-1:0]      pin_in,
  output logic [PPRS_NPIN-1:0]      periph_owned,
  input  wire logic [5:0]           ev_val,
  input  wire logic [5:0]           ev_en,
  input  wire logic [3:0]           tbl_val,
  input  wire logic [3:0]           tbl_en,
  input  wire logic [15:0]          ser_val,
  input  wire logic [15:0]          ser_drv,
  output logic [15:0]               ser_in,
  input  wire logic [1:0]           tw_val,
  input  wire logic [1:0]           tw_drv,
  output logic [1:0]                tw_in,
  input  wire logic [1:0]           tws_val,
  input  wire logic [1:0]           tws_drv,
  output logic [1:0]                tws_in,
  input  wire logic [3:0]           ss_val,
  input  wire logic [3:0]           ss_drv,
  output logic [3:0]                ss_in,
  input  wire logic [5:0]           ta_val,
  input  wire logic [5:0]           ta_en,
  input  wire logic [3:0]           tb_val,
  input  wire logic [3:0]           tb_en
);

  ////////////////////////////////////////////////////////////////////////
  // register file and bus slave

  logic [7:0]         route_q [PPRS_NREG];
  logic               aw_held;
  logic               w_held;
  logic [PPRS_AW-1:0] aw_addr_q;
  logic [7:0]         w_byte_q;
  logic               w_lane0_q;

  logic [7:0] event_output_route;
  logic [7:0] logic_table_output_route;
  logic [7:0] serial_port_route;
  logic [7:0] two_wire_and_sync_serial_route;
  logic [7:0] timer_a_output_route;
  logic [7:0] timer_b_output_route;

  assign event_output_route             = route_q[REG_EVENT];
  assign logic_table_output_route       = route_q[REG_TABLE];
  assign serial_port_route              = route_q[REG_SERIAL];
  assign two_wire_and_sync_serial_route = route_q[REG_TWSS];
  assign timer_a_output_route           = route_q[REG_TIMA];
  assign timer_b_output_route           = route_q[REG_TIMB];

  function automatic logic reg_hit(input logic [PPRS_AW-1:0] a);
    return (a[1:0] == 2'h0) && (a[PPRS_AW-1:2] < 6'(PPRS_NREG));
  endfunction

  function automatic logic [2:0] reg_idx(input logic [PPRS_AW-1:0] a);
    return a[4:2];
  endfunction

  // a frozen clock enable must not let a handshake slip past
  assign awready = ce & ~aw_held & ~bvalid;
  assign wready  = ce & ~w_held & ~bvalid;
  assign arready = ce & ~rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (aw_held && w_held && !bvalid)
      begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held    <= 1'b0;
      w_byte_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wvalid && wready)
      begin
        w_held    <= 1'b1;
        w_byte_q  <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      else if (aw_held && w_held && !bvalid)
      begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < PPRS_NREG; i++)
      begin
        route_q[i] <= ROUTE_RESET;
      end
    end
    else if (ce && aw_held && w_held && !bvalid)
    begin
      if (reg_hit(aw_addr_q) && w_lane0_q)
      begin
        // unused bits never store, so they read back as zero
        route_q[reg_idx(aw_addr_q)] <= w_byte_q & REG_MASK[reg_idx(aw_addr_q)];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_held && w_held && !bvalid)
      begin
        bvalid <= 1'b1;
        bresp  <= reg_hit(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid && bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        rvalid <= 1'b1;
        rdata  <= reg_hit(araddr) ? {24'h00_0000, route_q[reg_idx(araddr)]}
                                  : 32'h0000_0000;
        rresp  <= reg_hit(araddr) ? RESP_OKAY : RESP_DECERR;
      end
      else if (rvalid && rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin claims; later functions win where two claim one pin

  logic [PPRS_NPIN-1:0] own;
  logic [PPRS_NPIN-1:0] val;
  logic [1:0]           tw_code;
  logic [1:0]           ss_code;
  logic [2:0]           ta_code;

  assign tw_code = two_wire_and_sync_serial_route[TW_LSB+:2];
  assign ss_code = two_wire_and_sync_serial_route[SS_LSB+:2];
  assign ta_code = timer_a_output_route[2:0];

  always_comb
  begin
    logic [1:0] code;
    logic [5:0] p;
    code = 2'h0;
    p    = 6'h00;
    own  = '0;
    val  = '0;
    // event outputs, F..A on ports F..A
    for (int e = 0; e < 6; e++)
    begin
      if (!event_output_route[e])
      begin
        p = pin(3'(e), EV_BIT_DEF);
      end
      else
      begin
        p = pin(3'(e), EV_BIT_ALT);
      end
      // a reserved one on B, E, F drives nothing
      if (ev_en[e] && (!event_output_route[e] || EV_HAS_ALT[e]))
      begin
        own[p] = 1'b1;
        val[p] = ev_val[e];
      end
    end
    // lookup-table outputs
    for (int t = 0; t < 4; t++)
    begin
      p = pin(TBL_PORT[t], logic_table_output_route[t] ? TBL_BIT_ALT : TBL_BIT_DEF);
      if (tbl_en[t])
      begin
        own[p] = 1'b1;
        val[p] = tbl_val[t];
      end
    end
    // timer B channels
    for (int c = 0; c < 4; c++)
    begin
      if (timer_b_output_route[c])
      begin
        p = pin(TB_ALT_PORT[c], TB_ALT_BIT[c]);
      end
      else
      begin
        p = pin(TB_DEF_PORT[c], TB_DEF_BIT[c]);
      end
      if (tb_en[c])
      begin
        own[p] = 1'b1;
        val[p] = tb_val[c];
      end
    end
    // timer A, codes above port F are reserved and drive nothing
    if (ta_code <= TA_LAST_CODE)
    begin
      for (int b = 0; b < 6; b++)
      begin
        p = pin(ta_code, 3'(b));
        if (ta_en[b])
        begin
          own[p] = 1'b1;
          val[p] = ta_val[b];
        end
      end
    end
    // serial ports; input lanes only read the pin, never drive it
    for (int n = 0; n < 4; n++)
    begin
      code = serial_port_route[2*n+:2];
      for (int l = 0; l < 4; l++)
      begin
        if (code == ROUTE_DEFAULT && ser_drv[4*n+l])
        begin
          p = pin(SER_PORT[n], 3'(l));
          own[p] = 1'b1;
          val[p] = ser_val[4*n+l];
        end
        else if (code == ROUTE_ALT_ONE && l < SER_ALT_CNT[n] && ser_drv[4*n+l])
        begin
          p = pin(SER_PORT[n], SER_ALT_BASE + 3'(l));
          own[p] = 1'b1;
          val[p] = ser_val[4*n+l];
        end
        // reserved and none codes claim nothing
      end
    end
    // sync serial
    if (ss_code != ROUTE_NONE)
    begin
      for (int l = 0; l < 4; l++)
      begin
        p = pin(SS_PORT[ss_code], SS_BASE[ss_code] + 3'(l));
        if (ss_drv[l])
        begin
          own[p] = 1'b1;
          val[p] = ss_val[l];
        end
      end
    end
    // two-wire host pins and dual-mode target pins
    if (tw_code != ROUTE_NONE)
    begin
      for (int l = 0; l < 2; l++)
      begin
        p = pin(TW_HOST_PORT[tw_code], TW_BASE + 3'(l));
        if (tw_drv[l])
        begin
          own[p] = 1'b1;
          val[p] = tw_val[l];
        end
        p = pin(TW_TGT_PORT[tw_code], TW_BASE + 3'(l));
        if (tws_drv[l])
        begin
          own[p] = 1'b1;
          val[p] = tws_val[l];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad side

  pprs_sync #(
    .W (PPRS_NPIN)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       (pad_in),
    .q       (pin_in)
  );

  pprs_pad_drive #(
    .W (PPRS_NPIN)
  ) u_pad (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .own        (own),
    .val        (val),
    .gpio_out   (gpio_out),
    .gpio_drive (gpio_drive),
    .pad_out    (pad_out),
    .pad_oe_n   (pad_oe_n),
    .owned      (periph_owned)
  );

  ////////////////////////////////////////////////////////////////////////
  // peripheral inputs; a detached function sees idle high

  logic [15:0] next_ser_in;
  logic [1:0]  next_tw_in;
  logic [1:0]  next_tws_in;
  logic [3:0]  next_ss_in;

  always_comb
  begin
    logic [1:0] code;
    code        = 2'h0;
    next_ser_in = '1;
    next_tw_in  = '1;
    next_tws_in = '1;
    next_ss_in  = '1;
    for (int n = 0; n < 4; n++)
    begin
      code = serial_port_route[2*n+:2];
      for (int l = 0; l < 4; l++)
      begin
        if (code == ROUTE_DEFAULT)
        begin
          next_ser_in[4*n+l] = pin_in[pin(SER_PORT[n], 3'(l))];
        end
        else if (code == ROUTE_ALT_ONE && l < SER_ALT_CNT[n])
        begin
          next_ser_in[4*n+l] = pin_in[pin(SER_PORT[n], SER_ALT_BASE + 3'(l))];
        end
      end
    end
    if (ss_code != ROUTE_NONE)
    begin
      for (int l = 0; l < 4; l++)
      begin
        next_ss_in[l] = pin_in[pin(SS_PORT[ss_code], SS_BASE[ss_code] + 3'(l))];
      end
    end
    if (tw_code != ROUTE_NONE)
    begin
      for (int l = 0; l < 2; l++)
      begin
        next_tw_in[l]  = pin_in[pin(TW_HOST_PORT[tw_code], TW_BASE + 3'(l))];
        next_tws_in[l] = pin_in[pin(TW_TGT_PORT[tw_code], TW_BASE + 3'(l))];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ser_in <= '1;
      tw_in  <= '1;
      tws_in <= '1;
      ss_in  <= '1;
    end
    else if (ce)
    begin
      ser_in <= next_ser_in;
      tw_in  <= next_tw_in;
      tws_in <= next_tws_in;
      ss_in  <= next_ss_in;
    end
  end

endmodule

/* File: logic/pprs_pkg.sv */
// Purpose: constants for the peripheral pin route select block
// Assumes: six ports of eight pins, pin index = {port, bit}
// Notes:   register index times four is the byte address
package pprs_pkg;

  localparam int PPRS_NPIN  = 48;
  localparam int PPRS_NREG  = 6;
  localparam int PPRS_AW    = 8;

  localparam logic [2:0] PORT_A = 3'h0;
  localparam logic [2:0] PORT_B = 3'h1;
  localparam logic [2:0] PORT_C = 3'h2;
  localparam logic [2:0] PORT_D = 3'h3;
  localparam logic [2:0] PORT_E = 3'h4;
  localparam logic [2:0] PORT_F = 3'h5;

  // register indices
  localparam logic [2:0] REG_EVENT = 3'h0;
  localparam logic [2:0] REG_TABLE = 3'h1;
  localparam logic [2:0] REG_SERIAL = 3'h2;
  localparam logic [2:0] REG_TWSS  = 3'h3;
  localparam logic [2:0] REG_TIMA  = 3'h4;
  localparam logic [2:0] REG_TIMB  = 3'h5;

  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] REG_MASK [PPRS_NREG] =
    '{8'h3f, 8'h0f, 8'hff, 8'h33, 8'h07, 8'h0f};

  localparam int TW_LSB = 4;
  localparam int SS_LSB = 0;

  localparam logic [1:0] ROUTE_DEFAULT = 2'h0;
  localparam logic [1:0] ROUTE_ALT_ONE = 2'h1;
  localparam logic [1:0] ROUTE_ALT_TWO = 2'h2;
  localparam logic [1:0] ROUTE_NONE    = 2'h3;

  localparam logic [2:0] EV_BIT_DEF  = 3'h2;
  localparam logic [2:0] EV_BIT_ALT  = 3'h7;
  localparam logic [5:0] EV_HAS_ALT  = 6'h0d;
  localparam logic [2:0] TBL_BIT_DEF = 3'h3;
  localparam logic [2:0] TBL_BIT_ALT = 3'h6;
  localparam logic [2:0] TBL_PORT [4] = '{PORT_A, PORT_C, PORT_D, PORT_F};
  localparam logic [2:0] SER_PORT [4] = '{PORT_A, PORT_C, PORT_F, PORT_B};
  localparam int         SER_ALT_CNT [4] = '{4, 4, 3, 2};
  localparam logic [2:0] SER_ALT_BASE = 3'h4;
  localparam logic [2:0] SS_PORT [3] = '{PORT_A, PORT_C, PORT_E};
  localparam logic [2:0] SS_BASE [3] = '{3'h4, 3'h0, 3'h0};
  localparam logic [2:0] TW_HOST_PORT [3] = '{PORT_A, PORT_A, PORT_C};
  localparam logic [2:0] TW_TGT_PORT [3] = '{PORT_C, PORT_F, PORT_F};
  localparam logic [2:0] TW_BASE = 3'h2;
  localparam logic [2:0] TA_LAST_CODE = 3'h5;
  localparam logic [2:0] TB_DEF_PORT [4] = '{PORT_A, PORT_A, PORT_C, PORT_B};
  localparam logic [2:0] TB_DEF_BIT [4] = '{3'h2, 3'h3, 3'h0, 3'h5};
  localparam logic [2:0] TB_ALT_PORT [4] = '{PORT_F, PORT_F, PORT_B, PORT_C};
  localparam logic [2:0] TB_ALT_BIT [4] = '{3'h4, 3'h5, 3'h4, 3'h1};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  function automatic logic [5:0] pin(input logic [2:0] p, input logic [2:0] b);
    return {p, b};
  endfunction

endpackage

/* File: logic/pprs_sync.sv */
// Purpose: two flop synchroniser for pad inputs
// Assumes: inputs are asynchronous to aclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pprs_sync #(
  parameter int W = 48
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: logic/pprs_pad_drive.sv */
// Purpose: registered pad drive, peripheral override over port control
// Assumes: own/val from peripherals, gpio_* from port logic, same clock
// Notes:   pad_oe_n low means the pad is driven
`timescale 1ns/1ps
module pprs_pad_drive
  import pprs_pkg::*;
#(
  parameter int W = PPRS_NPIN
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] own,
  input  wire logic [W-1:0] val,
  input  wire logic [W-1:0] gpio_out,
  input  wire logic [W-1:0] gpio_drive,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe_n,
  output logic      [W-1:0] owned
);

  // pads come out of reset released, as plain inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pad_out  <= '0;
      pad_oe_n <= '1;
      owned    <= '0;
    end
    else if (ce)
    begin
      pad_out  <= (own & val) | (~own & gpio_out);
      pad_oe_n <= ~(own | gpio_drive);
      owned    <= own;
    end
  end

endmodule

/* File: tb/pprs_top_sva.sv */
// Purpose: bus and pin checks on the route block ports
// Assumes: one clock, reset synchronous and active low
// Notes:   bound to every pprs_top instance
`timescale 1ns/1ps
module pprs_top_sva
  import pprs_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [47:0] gpio_out,
  input wire logic [47:0] gpio_drive,
  input wire logic [47:0] pad_out,
  input wire logic [47:0] pad_oe_n,
  input wire logic [47:0] periph_owned
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////
  sequence s_aw;
    awvalid && awready;
  endsequence
  sequence s_w;
    wvalid && wready;
  endsequence
  property p_reset_clear;
    $rose(aresetn) |-> !bvalid && !rvalid && periph_owned == '0 && pad_oe_n == '1;
  endproperty
  property p_wr_answer;
    s_aw ##0 s_w |-> ##[1:2] bvalid;
  endproperty
  property p_rd_answer;
    arvalid && arready |=> rvalid ##0 (rdata[31:8] == 24'h000000);
  endproperty
  property p_r_release;
    rvalid && rready |=> !rvalid;
  endproperty
  property p_b_release;
    bvalid && bready |=> !bvalid;
  endproperty
  property p_wr_block;
    bvalid |-> !awready && !wready;
  endproperty
  // owned pins drop the port drive enable; others follow it one cycle late
  property p_oe;
    ce |=> pad_oe_n == ~(periph_owned | $past(gpio_drive));
  endproperty
  property p_gpio;
    ce |=> ((pad_out ^ $past(gpio_out)) & ~periph_owned) == '0;
  endproperty

  ////////////////////////////////////////
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not idle after reset");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response missing");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late or upper bits set");
  a_r_release: assert property (p_r_release)
    else $error("read data not released");
  a_b_release: assert property (p_b_release)
    else $error("write response not released");
  a_wr_block: assert property (p_wr_block)
    else $error("write taken while response pending");
  a_oe: assert property (p_oe)
    else $error("pad drive enable wrong");
  a_gpio: assert property (p_gpio)
    else $error("free pin not under port control");
endmodule

bind pprs_top pprs_top_sva i_sva (.*);

/* File: tb/pprs_far.sv */
// Purpose: far side model, peripherals and port logic
// Assumes: cls picks the one peripheral class allowed to drive
// Notes:   one class at a time keeps overlapping claims out of play, except bench two-wire drive beside class 5 sync serial
`timescale 1ns/1ps
module pprs_far
  import pprs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic [2:0]  cls,
  input  wire logic [63:0] pat,
  output logic      [47:0] gpio_out,
  output logic      [47:0] gpio_drive,
  output logic      [47:0] pad_in,
  output logic      [5:0]  ev_val,
  output logic      [5:0]  ev_en,
  output logic      [3:0]  tbl_val,
  output logic      [3:0]  tbl_en,
  output logic      [15:0] ser_val,
  output logic      [15:0] ser_drv,
  output logic      [5:0]  ta_val,
  output logic      [5:0]  ta_en,
  output logic      [3:0]  tb_val,
  output logic      [3:0]  tb_en,
  output logic      [3:0]  ss_val,
  output logic      [3:0]  ss_drv
);
  logic [15:0] e;

  // enables biased high so most functions claim their pins
  assign e = pat[63:48] | pat[31:16];

  always_ff @(posedge aclk)
  begin
    gpio_out   <= pat[47:0];
    gpio_drive <= {pat[15:0], pat[63:32]};
    pad_in     <= ~pat[47:0];
    ev_val     <= pat[5:0];
    tbl_val    <= pat[9:6];
    ser_val    <= pat[25:10];
    ta_val     <= pat[31:26];
    tb_val     <= pat[35:32];
    ss_val     <= pat[39:36];
    ev_en      <= (cls == 3'h0) ? e[5:0] : 6'h00;
    tbl_en     <= (cls == 3'h1) ? e[3:0] : 4'h0;
    tb_en      <= (cls == 3'h2) ? e[3:0] : 4'h0;
    ta_en      <= (cls == 3'h3) ? e[5:0] : 6'h00;
    ser_drv    <= (cls == 3'h4) ? e : 16'h0000;
    ss_drv     <= (cls == 3'h5) ? e[3:0] : 4'h0;
  end
endmodule

/* File: tb/peripheral_pin_route_select_test.sv */
// Purpose: self-checking bench for the pin route block
// Assumes: AXI4-Lite master tasks, far side in pprs_far
// Notes:   expected pins come from an integer model of the routing
`timescale 1ns/1ps
module peripheral_pin_route_select_test;
  import pprs_pkg::*;
  logic        aclk;
  logic        aresetn;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [2:0]  cls;
  logic [63:0] pat;
  logic        ce = 1'b1;
  logic [1:0]  tw_val = 2'h0, tw_drv = 2'h0, tws_val = 2'h0, tws_drv = 2'h0;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp, tw_in, tws_in;
  wire  [31:0] rdata;
  wire  [47:0] gpio_out, gpio_drive, pad_in, pad_out, pad_oe_n, pin_in, periph_owned;
  wire  [5:0]  ev_val, ev_en, ta_val, ta_en;
  wire  [3:0]  tbl_val, tbl_en, tb_val, tb_en, ss_val, ss_drv, ss_in;
  wire  [15:0] ser_val, ser_drv, ser_in;
  int          n_errors, checked, m[6];
  int          tp[4] = '{0, 2, 3, 5}, sp[4] = '{0, 2, 5, 1}, sn[4] = '{4, 4, 3, 2};
  int          bd[4] = '{2, 3, 16, 13}, ba[4] = '{44, 45, 12, 17}, qp[3] = '{4, 16, 32};
  int          rmap[6] = '{0, 1, 5, 4, 2, 3};
  logic [31:0] rs = 32'd62461;
  logic [47:0] eo, ev;
  logic [15:0] es;
  logic [3:0]  eq;
  logic [1:0]  et, ets;

  pprs_top i_dut (.*);
  pprs_far i_far (.*);

  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic void put(int p, logic b);
    eo[p] = 1'b1;
    ev[p] = b;
  endfunction

  // software side never writes reserved codes
  function automatic logic [31:0] legal(int i, logic [31:0] v);
    if (i == 0) v &= 32'hffffffcd;
    if (i == 2) v |= (v >> 1) & 32'h55;
    if (i == 3 && v[5:4] == 2'h3) v[4] = 1'b0;
    if (i == 4 && v[2:1] == 2'h3) v[2] = 1'b0;
    return v;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("counts: %0d checks, %0d errors", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      b  = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t, v;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = arvalid && arready;
      v = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (t) arvalid <= 1'b0;
    end while (!v);
    rready <= 1'b0;
  endtask

  task automatic mwr(int i, logic [31:0] d);
    logic [1:0] r;
    wr(8'(i * 4), d, r);
    chk(r, RESP_OKAY);
    m[i] = d & REG_MASK[i];
  endtask

  task automatic rd_all();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(i * 4), d, r);
      chk(d, m[i]);
      chk(r, RESP_OKAY);
    end
  endtask

  task automatic model();
    int c, w, h, g;
    eo = '0;
    ev = gpio_out;
    es = '1;
    eq = '1;
    {et, ets} = '1;
    for (int t = 0; t < 16; t++)
    begin
      c = (m[2] >> (t / 4 * 2)) & 3;
      if (cls == 0 && t < 6 && ev_en[t] && (m[0][t] == 0 || t inside {0, 2, 3}))
        put(t * 8 + (m[0][t] ? 7 : 2), ev_val[t]);
      if (cls == 1 && t < 4 && tbl_en[t]) put(tp[t] * 8 + (m[1][t] ? 6 : 3), tbl_val[t]);
      if (cls == 2 && t < 4 && tb_en[t]) put(m[5][t] ? ba[t] : bd[t], tb_val[t]);
      if (cls == 3 && t < 6 && ta_en[t]) put((m[4] & 7) * 8 + t, ta_val[t]);
      if (cls == 4 && ser_drv[t] && (c == 0 || (c == 1 && t % 4 < sn[t / 4])))
        put(sp[t / 4] * 8 + t % 4 + c * 4, ser_val[t]);
      if (cls == 5 && t < 4 && ss_drv[t] && (m[3] & 3) < 3)
        put(qp[m[3] & 3] + t, ss_val[t]);
      if (c == 0 || (c == 1 && t % 4 < sn[t / 4]))
        es[t] = pad_in[sp[t / 4] * 8 + t % 4 + c * 4];
      if (t < 4 && (m[3] & 3) < 3)
        eq[t] = pad_in[qp[m[3] & 3] + t];
    end
    // two-wire claims come last, they win over sync serial on shared pins
    w = (m[3] >> 4) & 3;
    for (int l = 0; l < 2 && w < 3; l++)
    begin
      h = (w == 2 ? 16 : 0) + 2 + l;
      g = (w == 0 ? 16 : 40) + 2 + l;
      et[l] = pad_in[h];
      ets[l] = pad_in[g];
      if (tw_drv[l]) put(h, tw_val[l]);
      if (tws_drv[l]) put(g, tws_val[l]);
    end
  endtask

  ////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    conclude();
  end

  initial
  begin
    logic [31:0] d, v;
    logic [1:0]  r;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, cls, pat} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_all();
    for (int i = 0; i < 6; i++) mwr(i, legal(i, rnd()));
    rd_all();
    rd(8'h18, d, r);
    chk(r, RESP_DECERR);
    chk(d, 32'h0);
    wr(8'h05, 32'hff, r);
    chk(r, RESP_DECERR);
    rd_all();
    $display("register test finished");
    for (int c = 0; c < 6; c++)
    begin
      for (int k = 0; k < 12; k++)
      begin
        v = legal(rmap[c], rnd());
        if (c == 3) v[2:0] = 3'(k % 6);
        if (c == 5) v[5:0] = {2'(k % 3), 2'h0, 2'(k)};
        mwr(rmap[c], v);
        pat <= {rnd(), rnd()};
        cls <= 3'(c);
        {tw_val, tw_drv, tws_val, tws_drv} <= (c == 5) ? 8'(rnd()) : 8'h00;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        model();
        chk(periph_owned, eo);
        chk(pad_out, ev);
        chk(pad_oe_n, 48'(~(eo | gpio_drive)));
        chk(pin_in, pad_in);
        chk({ser_in, ss_in}, {es, eq});
        chk({tw_in, tws_in}, {et, ets});
      end
      $display("route test %0d finished", c);
    end
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    m = '{0, 0, 0, 0, 0, 0};
    rd_all();
    $display("reset test finished");
    conclude();
  end
endmodule
